// File: core/usb_in_endpoint_transfer.sv
// USB full-speed IN transfer engine, endpoint registers and interrupt mapping
// Behaviour
// [RULE1] IN token without data-valid gets NAK only
// [RULE2] Software loads EP0 bytes, count, then valid
// [RULE3] Software fills shared buffer from base pointer
// [RULE4] Host ACK clears valid, sets transfer-done flag
// [RULE5] Endpoint and system interrupt requests from flags
// [RULE6] EP0 data: read OUT, write IN, no reset
// [RULE7] 64-byte buffer in eight pages, 3-bit bases
// [RULE8] Missing ACK resends same data next token
// [RULE9] Per-endpoint enables; EP0 enable covers IN/OUT
// [RULE10] Interrupt held while enabled flag stays set
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
module usb_in_endpoint_transfer #(
    parameter int BUF_DEPTH = 64,
    parameter int BUF_ADDR_W = 6
) (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    input wire logic IN_TOKEN,
    input wire logic [2:0] IN_EP,
    input wire logic HOST_ACK,
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic TX_END,
    output logic NAK_SEND,
    input wire logic RX_WE,
    input wire logic [2:0] RX_IDX,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_DONE,
    input wire logic EVT_SETUP,
    input wire logic EVT_SOF,
    input wire logic EVT_CONFIG,
    input wire logic EVT_BUSRST,
    input wire logic EVT_RESUME,
    input wire logic EVT_SUSPEND,
    output logic IRQ_EP,
    output logic IRQ_SYS,
    output logic [3:0] EP_IF_SEL
);
    localparam int CW = usb_in_pkg::CNT_W;
    localparam int NE = usb_in_pkg::NUM_EP;
    localparam int FW = usb_in_pkg::FLAG_W;

    // Bus data phase tracking
    logic dp_rd_q;
    logic dp_wr_q;
    logic dp_ok_q;
    logic rd_done_q;
    logic [7:0] dp_idx_q;
    logic [31:0] hrdata_q;
    logic [31:0] rdata_d;
    logic addr_phase;
    logic wr_go;
    logic [3:0] slot_dp;

    // Register state
    logic [7:0] ep0_in_q [8];
    logic [7:0] ep0_out_q [8];
    logic [7:0] base12_q;
    logic [7:0] base34_q;
    logic [7:0] ifsel_q;
    logic [NE-1:0] valid_q;
    logic [NE*CW-1:0] count_q;
    logic [FW-1:0] flag_q;
    logic [FW-1:0] enable_q;
    logic [FW-1:0] flag_set;
    logic [FW-1:0] flag_clr;
    logic [FW-1:0] enable_eff;

    // Transmit engine
    usb_in_pkg::tx_state_e state_q;
    usb_in_pkg::tx_state_e state_d;
    logic [2:0] ep_q;
    logic [CW-1:0] idx_q;
    logic [7:0] tx_data_q;
    logic [CW-1:0] cnt_sel;
    logic [2:0] base_sel;
    logic [BUF_ADDR_W-1:0] ram_rd_addr;
    logic [7:0] ram_rd_a;
    logic [7:0] ram_rd_b;
    logic tok_ok;
    logic ack_done;
    logic ram_wr;

    // Maps an index to an EP0 byte slot; bit 3 marks a hit
    function automatic logic [3:0] ep0_slot(input logic [7:0] idx);
        logic [3:0] s;
        s = 4'h0;
        if (idx == usb_in_pkg::IDX_EP0_B0) s = 4'h8;
        if (idx == usb_in_pkg::IDX_EP0_B1) s = 4'h9;
        if (idx == usb_in_pkg::IDX_EP0_B2) s = 4'ha;
        if (idx == usb_in_pkg::IDX_EP0_B3) s = 4'hb;
        if (idx == usb_in_pkg::IDX_EP0_B4) s = 4'hc;
        if (idx == usb_in_pkg::IDX_EP0_B5) s = 4'hd;
        if (idx == usb_in_pkg::IDX_EP0_B6) s = 4'he;
        if (idx == usb_in_pkg::IDX_EP0_B7) s = 4'hf;
        return s;
    endfunction

    // Address phase is taken for any transfer size; dp_ok_q then admits only word-sized ones
    assign addr_phase = HSEL & HREADY & HTRANS[1];
    assign wr_go = dp_wr_q & dp_ok_q;
    assign slot_dp = ep0_slot(dp_idx_q);

    // Reads insert one wait state so that read data leave a flip-flop
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            dp_rd_q <= 1'b0;
            dp_wr_q <= 1'b0;
            dp_ok_q <= 1'b0;
            rd_done_q <= 1'b0;
            dp_idx_q <= 8'h00;
        end else if (HREADY) begin
            dp_rd_q <= addr_phase & ~HWRITE;
            dp_wr_q <= addr_phase & HWRITE;
            dp_ok_q <= (HADDR[31:10] == 22'h000000) && (HADDR[1:0] == 2'b00)
                && (HSIZE == usb_in_pkg::HSIZE_WORD);
            dp_idx_q <= HADDR[9:2];
            rd_done_q <= 1'b0;
        end else begin
            rd_done_q <= 1'b1;
        end
    end

    assign HREADYOUT = ~(dp_rd_q & ~rd_done_q);
    assign HRESP = usb_in_pkg::HRESP_OKAY;
    assign HRDATA = hrdata_q;

    // Read mux; unmapped or malformed addresses read zero
    always_comb begin
        rdata_d = 32'h00000000;
        if (!dp_ok_q) begin
            rdata_d = 32'h00000000;
        end else if (dp_idx_q[7:6] == usb_in_pkg::IDX_RAM_TOP) begin
            rdata_d = {24'h000000, ram_rd_a};
        end else if (slot_dp[3]) begin
            rdata_d = {24'h000000, ep0_out_q[slot_dp[2:0]]}; // [RULE6]
        end else if (dp_idx_q == usb_in_pkg::IDX_BASE12) begin
            rdata_d = {24'h000000, base12_q};
        end else if (dp_idx_q == usb_in_pkg::IDX_BASE34) begin
            rdata_d = {24'h000000, base34_q};
        end else if (dp_idx_q == usb_in_pkg::IDX_IFSEL) begin
            rdata_d = {24'h000000, ifsel_q};
        end else if (dp_idx_q == usb_in_pkg::IDX_VALID) begin
            rdata_d = {27'h0000000, valid_q};
        end else if (dp_idx_q == usb_in_pkg::IDX_COUNT) begin
            rdata_d = {12'h000, count_q};
        end else if (dp_idx_q == usb_in_pkg::IDX_STATUS) begin
            rdata_d = {18'h00000, flag_q};
        end else if (dp_idx_q == usb_in_pkg::IDX_ENABLE) begin
            rdata_d = {18'h00000, enable_q};
        end
    end

    // Capture read data in the wait cycle
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            hrdata_q <= 32'h00000000;
        end else if (dp_rd_q && !rd_done_q) begin
            hrdata_q <= rdata_d;
        end
    end

    // EP0 IN bytes from software, OUT bytes from the receive side; never reset
    always_ff @(posedge CLK_SYS) begin
        if (wr_go && slot_dp[3]) begin
            ep0_in_q[slot_dp[2:0]] <= HWDATA[7:0]; // [RULE6]
        end
        if (RX_WE) begin
            ep0_out_q[RX_IDX] <= RX_DATA; // [RULE6]
        end
    end

    // Base pointers and interface selection
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            base12_q <= usb_in_pkg::RST_BYTE_REG;
            base34_q <= usb_in_pkg::RST_BYTE_REG;
            ifsel_q <= usb_in_pkg::RST_BYTE_REG;
        end else if (wr_go) begin
            if (dp_idx_q == usb_in_pkg::IDX_BASE12) begin
                base12_q <= HWDATA[7:0] & usb_in_pkg::BASE_MASK;
            end
            if (dp_idx_q == usb_in_pkg::IDX_BASE34) begin
                base34_q <= HWDATA[7:0] & usb_in_pkg::BASE_MASK;
            end
            if (dp_idx_q == usb_in_pkg::IDX_IFSEL) begin
                ifsel_q <= HWDATA[7:0] & usb_in_pkg::IFSEL_MASK;
            end
        end
    end

    assign EP_IF_SEL = {ifsel_q[6], ifsel_q[4], ifsel_q[2], ifsel_q[0]};

    // Byte counts; software writes them before raising valid
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            count_q <= usb_in_pkg::RST_COUNT;
        end else if (wr_go && dp_idx_q == usb_in_pkg::IDX_COUNT) begin
            count_q <= HWDATA[NE*CW-1:0];
        end
    end

    // Data-valid: a software write takes precedence over the ACK clear
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            valid_q <= usb_in_pkg::RST_VALID;
        end else if (wr_go && dp_idx_q == usb_in_pkg::IDX_VALID) begin
            valid_q <= HWDATA[NE-1:0];
        end else if (ack_done) begin
            valid_q[ep_q] <= 1'b0; // [RULE4]
        end
    end

    // Shared buffer writes from the bus window
    assign ram_wr = wr_go && (dp_idx_q[7:6] == usb_in_pkg::IDX_RAM_TOP);

    ep_buffer_ram #(
        .DATA_W(8),
        .DEPTH(BUF_DEPTH),
        .ADDR_W(BUF_ADDR_W)
    ) u_buf (
        .clk(CLK_SYS),
        .wr_en(ram_wr),
        .wr_addr(dp_idx_q[BUF_ADDR_W-1:0]),
        .wr_data(HWDATA[7:0]),
        .rd_addr_a(HADDR[BUF_ADDR_W+1:2]),
        .rd_data_a(ram_rd_a),
        .rd_addr_b(ram_rd_addr),
        .rd_data_b(ram_rd_b)
    );

    // Selected endpoint count, clamped to eight bytes on EP0
    always_comb begin
        cnt_sel = count_q[ep_q*CW +: CW];
        if (ep_q == 3'd0 && cnt_sel > usb_in_pkg::EP0_MAX_BYTES) begin
            cnt_sel = usb_in_pkg::EP0_MAX_BYTES;
        end
    end

    // Base page per endpoint; each page is eight bytes
    always_comb begin
        unique case (ep_q)
            3'd1: base_sel = base12_q[2:0];
            3'd2: base_sel = base12_q[6:4];
            3'd3: base_sel = base34_q[2:0];
            3'd4: base_sel = base34_q[6:4];
            default: base_sel = 3'd0;
        endcase
    end

    // Offsets wrap within the buffer rather than run off its end
    assign ram_rd_addr = {base_sel, 3'b000}
        + {{(BUF_ADDR_W-CW){1'b0}}, idx_q}; // [RULE7]

    // A token is served only if its endpoint exists and holds valid data
    assign tok_ok = (IN_EP < 3'(NE)) && valid_q[IN_EP];
    assign ack_done = (state_q == usb_in_pkg::ST_WAIT_ACK) && HOST_ACK;

    // Transmit engine next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            usb_in_pkg::ST_IDLE,
            usb_in_pkg::ST_WAIT_ACK: begin
                if (ack_done) begin
                    state_d = usb_in_pkg::ST_IDLE; // [RULE4]
                end else if (IN_TOKEN && !tok_ok) begin
                    state_d = usb_in_pkg::ST_NAK; // [RULE1]
                end else if (IN_TOKEN) begin
                    state_d = usb_in_pkg::ST_FETCH; // [RULE8]
                end
            end
            usb_in_pkg::ST_NAK: state_d = usb_in_pkg::ST_IDLE;
            usb_in_pkg::ST_FETCH: begin
                state_d = (cnt_sel == '0) ? usb_in_pkg::ST_ENDP : usb_in_pkg::ST_GRAB;
            end
            usb_in_pkg::ST_GRAB: state_d = usb_in_pkg::ST_SEND;
            usb_in_pkg::ST_SEND: begin
                if (TX_READY) begin
                    state_d = (idx_q == cnt_sel - 1'b1) ? usb_in_pkg::ST_ENDP
                        : usb_in_pkg::ST_FETCH;
                end
            end
            usb_in_pkg::ST_ENDP: state_d = usb_in_pkg::ST_WAIT_ACK;
            default: state_d = usb_in_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            state_q <= usb_in_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Endpoint latch and byte index; a repeat token restarts at byte zero
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ep_q <= 3'd0;
            idx_q <= '0;
        end else if (state_d == usb_in_pkg::ST_FETCH
            && (state_q == usb_in_pkg::ST_IDLE || state_q == usb_in_pkg::ST_WAIT_ACK)) begin
            ep_q <= IN_EP; // [RULE8]
            idx_q <= '0;
        end else if (state_q == usb_in_pkg::ST_SEND && TX_READY) begin
            idx_q <= idx_q + 1'b1;
        end
    end

    // Byte to send: EP0 from its own registers, others from the buffer
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            tx_data_q <= 8'h00;
        end else if (state_q == usb_in_pkg::ST_GRAB) begin
            tx_data_q <= (ep_q == 3'd0) ? ep0_in_q[idx_q[2:0]] : ram_rd_b;
        end
    end

    assign TX_DATA = tx_data_q;
    assign TX_VALID = (state_q == usb_in_pkg::ST_SEND);
    assign TX_END = (state_q == usb_in_pkg::ST_ENDP);
    assign NAK_SEND = (state_q == usb_in_pkg::ST_NAK); // [RULE1]

    // Event sources for the sticky flags
    always_comb begin
        flag_set = '0;
        if (ack_done) begin
            flag_set[ep_q + 3'd1 - ((ep_q == 3'd0) ? 3'd1 : 3'd0)] = 1'b1; // [RULE4]
        end
        flag_set[usb_in_pkg::FLAG_EP0_RX] = RX_DONE;
        flag_set[usb_in_pkg::FLAG_SETUP] = EVT_SETUP;
        flag_set[usb_in_pkg::FLAG_SOF] = EVT_SOF;
        flag_set[usb_in_pkg::FLAG_CONFIG] = EVT_CONFIG;
        flag_set[usb_in_pkg::FLAG_BUSRST] = EVT_BUSRST;
        flag_set[usb_in_pkg::FLAG_RESUME] = EVT_RESUME;
        flag_set[usb_in_pkg::FLAG_SUSPEND] = EVT_SUSPEND;
    end

    assign flag_clr = (wr_go && dp_idx_q == usb_in_pkg::IDX_CLEAR) ? HWDATA[FW-1:0] : '0;

    // Sticky flags; a new event in the clearing cycle survives the clear
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            flag_q <= usb_in_pkg::RST_FLAGS;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | flag_set;
        end
    end

    // Interrupt enables
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            enable_q <= usb_in_pkg::RST_FLAGS;
        end else if (wr_go && dp_idx_q == usb_in_pkg::IDX_ENABLE) begin
            enable_q <= HWDATA[FW-1:0] & usb_in_pkg::ENABLE_MASK;
        end
    end

    // The EP0 enable gates both EP0 completion flags
    always_comb begin
        enable_eff = enable_q;
        enable_eff[usb_in_pkg::FLAG_EP0_RX] = enable_q[usb_in_pkg::FLAG_EP0_TX]; // [RULE9]
    end

    // Level requests, held until software clears every enabled flag
    assign IRQ_EP = |(flag_q & enable_eff & usb_in_pkg::EP_FLAG_MASK); // [RULE5] [RULE10]
    assign IRQ_SYS = |(flag_q & enable_eff & usb_in_pkg::SYS_FLAG_MASK); // [RULE5] [RULE10]
endmodule

// File: core/usb_in_pkg.sv
// Shared constants for the USB IN endpoint transfer block
package usb_in_pkg;
    // Register indices; the bus byte address is four times the index
    localparam logic [7:0] IDX_EP0_B0 = 8'h40;
    localparam logic [7:0] IDX_EP0_B1 = 8'h41;
    localparam logic [7:0] IDX_EP0_B2 = 8'h42;
    localparam logic [7:0] IDX_EP0_B3 = 8'h43;
    localparam logic [7:0] IDX_EP0_B5 = 8'h44;
    localparam logic [7:0] IDX_EP0_B6 = 8'h45;
    localparam logic [7:0] IDX_EP0_B7 = 8'h46;
    localparam logic [7:0] IDX_EP0_B4 = 8'h47;
    localparam logic [7:0] IDX_VALID = 8'h48;
    localparam logic [7:0] IDX_COUNT = 8'h49;
    localparam logic [7:0] IDX_STATUS = 8'h4c;
    localparam logic [7:0] IDX_CLEAR = 8'h4d;
    localparam logic [7:0] IDX_ENABLE = 8'h4e;
    localparam logic [7:0] IDX_BASE12 = 8'h5d;
    localparam logic [7:0] IDX_BASE34 = 8'h5e;
    localparam logic [7:0] IDX_IFSEL = 8'h5f;
    // Shared buffer window occupies indices 0x80 to 0xbf
    localparam logic [1:0] IDX_RAM_TOP = 2'b10;

    // Reset values and writable bit masks
    localparam logic [7:0] RST_BYTE_REG = 8'h00;
    localparam logic [7:0] BASE_MASK = 8'h77;
    localparam logic [7:0] IFSEL_MASK = 8'h55;

    // Flag layout shared by status, clear and enable
    localparam int FLAG_W = 14;
    localparam int FLAG_EP0_TX = 0;
    localparam int FLAG_EP0_RX = 1;
    localparam int FLAG_SETUP = 8;
    localparam int FLAG_SOF = 9;
    localparam int FLAG_CONFIG = 10;
    localparam int FLAG_BUSRST = 11;
    localparam int FLAG_RESUME = 12;
    localparam int FLAG_SUSPEND = 13;
    localparam logic [FLAG_W-1:0] EP_FLAG_MASK = 14'h003f;
    localparam logic [FLAG_W-1:0] SYS_FLAG_MASK = 14'h3f00;
    localparam logic [FLAG_W-1:0] ENABLE_MASK = 14'h3f3d;
    localparam logic [FLAG_W-1:0] RST_FLAGS = 14'h0000;

    // Endpoints and packet sizing
    localparam int NUM_EP = 5;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] EP0_MAX_BYTES = 4'h8;
    localparam logic [NUM_EP*CNT_W-1:0] RST_COUNT = 20'h00000;
    localparam logic [NUM_EP-1:0] RST_VALID = 5'h00;

    // AHB-Lite encodings
    localparam logic [2:0] HSIZE_WORD = 3'b010;
    localparam logic HRESP_OKAY = 1'b0;

    // IN transfer engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_NAK = 3'b001,
        ST_FETCH = 3'b010,
        ST_GRAB = 3'b011,
        ST_SEND = 3'b100,
        ST_ENDP = 3'b101,
        ST_WAIT_ACK = 3'b110
    } tx_state_e;
endpackage

// File: core/ep_buffer_ram.sv
// Shared endpoint buffer: one write port, two registered read ports
`timescale 1ns/10ps
module ep_buffer_ram #(
    parameter int DATA_W = 8,
    parameter int DEPTH = 64,
    parameter int ADDR_W = 6
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [ADDR_W-1:0] rd_addr_a,
    output logic [DATA_W-1:0] rd_data_a,
    input wire logic [ADDR_W-1:0] rd_addr_b,
    output logic [DATA_W-1:0] rd_data_b
);
    logic [DATA_W-1:0] mem [DEPTH];

    // No reset: buffer contents are undefined until software fills them
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Bus read port, one cycle latency
    always_ff @(posedge clk) begin
        rd_data_a <= mem[rd_addr_a];
    end

    // Transmit engine read port, one cycle latency
    always_ff @(posedge clk) begin
        rd_data_b <= mem[rd_addr_b];
    end
endmodule

// File: bench/usb_in_props.sv
// Port-level timing checker for the USB IN transfer block
`timescale 1ns/10ps
module usb_in_props (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic IN_TOKEN,
    input wire logic HOST_ACK,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic TX_END,
    input wire logic NAK_SEND,
    input wire logic RX_DONE,
    input wire logic IRQ_EP,
    input wire logic IRQ_SYS
);
    // Bus request accepted at this edge
    wire tk = HSEL && HREADY && HTRANS[1];

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    // Bus timing: a read costs one wait, a write none
    okay_resp_a: assert property (HRESP == 1'b0) else $error("response not OKAY");
    read_wait_a: assert property (tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
    write_fast_a: assert property (tk && HWRITE |=> HREADYOUT) else $error("write stalled");
    // Link side: refusals and byte stream
    nak_cause_a: assert property (NAK_SEND |-> $past(IN_TOKEN) && !TX_VALID)
        else $error("NAK without a token");
    nak_pulse_a: assert property (NAK_SEND |=> !NAK_SEND) else $error("NAK longer than one cycle");
    tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("byte dropped while stalled");
    end_pulse_a: assert property (TX_END |=> !TX_END && !TX_VALID)
        else $error("packet end not a single pulse");
    // Interrupt levels only move for their causes
    irq_ep_rise_a: assert property (!$past(SYS_RST) && $rose(IRQ_EP) |->
        $past(HOST_ACK) || $past(RX_DONE) || $past(tk && HWRITE, 2))
        else $error("endpoint irq without cause");
    irq_ep_fall_a: assert property (!$past(SYS_RST) && $fell(IRQ_EP) |->
        $past(tk && HWRITE, 2)) else $error("endpoint irq dropped alone");
    irq_sys_fall_a: assert property (!$past(SYS_RST) && $fell(IRQ_SYS) |->
        $past(tk && HWRITE, 2)) else $error("system irq dropped alone");
endmodule

bind usb_in_endpoint_transfer usb_in_props chk_i (.*);

// File: bench/host_model.sv
// Behavioural USB host that issues IN tokens and collects packets
`timescale 1ns/10ps
module host_model (
    input wire logic clk,
    output logic in_token,
    output logic [2:0] in_ep,
    output logic host_ack,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_end,
    input wire logic nak_send
);
    logic [7:0] rx_q[$];

    // Quiet between transactions
    initial begin
        in_token = 1'b0;
        in_ep = 3'h0;
        host_ack = 1'b0;
        tx_ready = 1'b0;
    end

    // One IN transaction; slow stalls every other cycle, ack may be withheld
    task automatic in_xfer(input logic [2:0] ep, input bit ack, input bit slow, output bit nak);
        int n;
        rx_q.delete();
        nak = 1'b0;
        in_token <= 1'b1;
        in_ep <= ep;
        @(posedge clk);
        in_token <= 1'b0;
        in_ep <= ~ep; // Junk once the token is gone
        for (n = 0; n < 400; n++) begin
            tx_ready <= slow ? n[0] : 1'b1;
            @(posedge clk);
            if (tx_valid && tx_ready)
                rx_q.push_back(tx_data);
            if (nak_send || tx_end) begin
                nak = nak_send;
                break;
            end
        end
        tx_ready <= 1'b0;
        // Without the handshake the packet must stay armed
        if (ack && !nak) begin
            host_ack <= 1'b1;
            @(posedge clk);
            host_ack <= 1'b0;
        end
    endtask
endmodule

// File: bench/tb_usb_in_endpoint_transfer.sv
// Self-checking bench for the USB IN transfer block
`timescale 1ns/10ps
module tb_usb_in_endpoint_transfer;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic rx_we = 1'b0;
    logic [2:0] rx_idx = 3'h0;
    logic [7:0] rx_data = 8'h00;
    logic rx_done = 1'b0;
    logic [5:0] evt = 6'h00;
    logic hready, hresp, irq_ep, irq_sys, tok, ack, txv, txr, txe, nak_s;
    logic [31:0] hrdata;
    logic [7:0] txd;
    logic [2:0] iep;
    logic [3:0] ifsel;
    logic [31:0] seed = 32'he27a;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;

    // Free-running system clock
    initial begin
        forever #20 clk = ~clk;
    end

    usb_in_endpoint_transfer dut (.CLK_SYS(clk), .SYS_RST(sys_rst), .HSEL(1'b1),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(usb_in_pkg::HSIZE_WORD),
        .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRDATA(hrdata),
        .HRESP(hresp), .IN_TOKEN(tok), .IN_EP(iep), .HOST_ACK(ack), .TX_DATA(txd),
        .TX_VALID(txv), .TX_READY(txr), .TX_END(txe), .NAK_SEND(nak_s), .RX_WE(rx_we),
        .RX_IDX(rx_idx), .RX_DATA(rx_data), .RX_DONE(rx_done), .EVT_SETUP(evt[0]),
        .EVT_SOF(evt[1]), .EVT_CONFIG(evt[2]), .EVT_BUSRST(evt[3]), .EVT_RESUME(evt[4]),
        .EVT_SUSPEND(evt[5]), .IRQ_EP(irq_ep), .IRQ_SYS(irq_sys), .EP_IF_SEL(ifsel));

    host_model host (.clk(clk), .in_token(tok), .in_ep(iep), .host_ack(ack), .tx_ready(txr),
        .tx_data(txd), .tx_valid(txv), .tx_end(txe), .nak_send(nak_s));

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", w, x, g);
        end
    endtask

    // One word transfer; only the hang guard ends a wait
    task automatic bus(input bit w, input logic [7:0] idx, input logic [31:0] d,
                       output logic [31:0] q);
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rchk(input string w, input logic [7:0] idx, input logic [31:0] x);
        logic [31:0] q;
        bus(1'b0, idx, 32'h0, q);
        chk(w, x, q);
    endtask

    // Endpoint 0 byte i lives at a scattered index
    function automatic logic [7:0] ep0_idx(input int i);
        return i < 4 ? 8'(usb_in_pkg::IDX_EP0_B0 + i) : i == 4 ? usb_in_pkg::IDX_EP0_B4 :
            8'(usb_in_pkg::IDX_EP0_B5 + i - 5);
    endfunction

    task automatic pkt(input logic [7:0] e[$]);
        chk("pkt len", 32'(e.size()), 32'(host.rx_q.size()));
        foreach (e[i]) chk("pkt byte", e[i], host.rx_q[i]);
    endtask

    initial begin
        logic [31:0] r;
        logic [15:0] bs;
        logic [7:0] e[$];
        bit nk;
        int n, i, k;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk("irq pins", 0, {irq_sys, irq_ep, ifsel});
        rchk("base12", usb_in_pkg::IDX_BASE12, 0);
        rchk("base34", usb_in_pkg::IDX_BASE34, 0);
        rchk("ifsel", usb_in_pkg::IDX_IFSEL, 0);
        // Masks, read-only status and a hole in the map
        r = $random(seed);
        wr(usb_in_pkg::IDX_IFSEL, r);
        rchk("ifsel", usb_in_pkg::IDX_IFSEL, r & usb_in_pkg::IFSEL_MASK);
        chk("ifsel pins", {r[6], r[4], r[2], r[0]}, ifsel);
        wr(usb_in_pkg::IDX_STATUS, '1);
        rchk("status ro", usb_in_pkg::IDX_STATUS, 0);
        rchk("unmapped", 8'h4a, 0);
        wr(usb_in_pkg::IDX_ENABLE, '1);
        rchk("enable", usb_in_pkg::IDX_ENABLE, usb_in_pkg::ENABLE_MASK);
        for (n = 0; n < 6; n++) begin
            host.in_xfer(3'(n), 1'b1, 1'b0, nk);
            chk("nak", 1, nk);
        end
        // Endpoint 0: stalled send without ACK, then resend with ACK
        for (n = 0; n < 8; n++) begin
            e.push_back(8'($random(seed)));
            wr(ep0_idx(n), e[n]);
        end
        wr(usb_in_pkg::IDX_COUNT, 32'h8);
        wr(usb_in_pkg::IDX_VALID, 32'h1);
        host.in_xfer(3'h0, 1'b0, 1'b1, nk);
        pkt(e);
        rchk("no ack", usb_in_pkg::IDX_STATUS, 0);
        host.in_xfer(3'h0, 1'b1, 1'b0, nk);
        pkt(e);
        rchk("ep0 done", usb_in_pkg::IDX_STATUS, 1);
        rchk("ep0 valid", usb_in_pkg::IDX_VALID, 0);
        chk("ep0 irq", 1, irq_ep);
        wr(usb_in_pkg::IDX_CLEAR, 1);
        @(posedge clk);
        chk("ep0 irq clr", 0, irq_ep);
        // OUT bytes read back; ep0 enable gates the receive flag too
        wr(usb_in_pkg::IDX_ENABLE, usb_in_pkg::SYS_FLAG_MASK);
        e.delete();
        for (n = 0; n < 8; n++) begin
            e.push_back(8'($random(seed)));
            rx_we <= 1'b1;
            rx_idx <= 3'(n);
            rx_data <= e[n];
            @(posedge clk);
        end
        rx_we <= 1'b0;
        rx_done <= 1'b1;
        @(posedge clk);
        rx_done <= 1'b0;
        for (n = 0; n < 8; n++) rchk("ep0 out", ep0_idx(n), e[n]);
        chk("rx masked", 0, irq_ep);
        wr(usb_in_pkg::IDX_ENABLE, 1);
        @(posedge clk);
        chk("rx irq", 1, irq_ep);
        wr(usb_in_pkg::IDX_CLEAR, 2);
        // Endpoints 1 to 4 from random pages, zero and fifteen bytes included
        wr(usb_in_pkg::IDX_ENABLE, usb_in_pkg::ENABLE_MASK);
        bs = 16'($random(seed)) & 16'h7777;
        wr(usb_in_pkg::IDX_BASE12, bs[7:0]);
        wr(usb_in_pkg::IDX_BASE34, bs[15:8]);
        rchk("base34", usb_in_pkg::IDX_BASE34, bs[15:8]);
        for (n = 1; n < 5; n++) begin
            k = n == 1 ? 0 : n == 4 ? 15 : $random(seed) & 15;
            e.delete();
            for (i = 0; i < k; i++) begin
                e.push_back(8'($random(seed)));
                wr({2'b10, 6'(bs[4*n-4 +: 3] * 8 + i)}, e[i]);
            end
            wr(usb_in_pkg::IDX_COUNT, k << (4 * n));
            wr(usb_in_pkg::IDX_VALID, 1 << n);
            host.in_xfer(3'(n), 1'b1, n[0], nk);
            pkt(e);
            rchk("ep done", usb_in_pkg::IDX_STATUS, 1 << (n + 1));
            chk("ep irq", 1, irq_ep);
            wr(usb_in_pkg::IDX_CLEAR, 32'h3fff);
        end
        // Each system event, masked then enabled then cleared
        for (n = 0; n < 6; n++) begin
            wr(usb_in_pkg::IDX_ENABLE, usb_in_pkg::EP_FLAG_MASK);
            evt <= 6'(1 << n);
            @(posedge clk);
            evt <= 6'h00;
            rchk("sys flag", usb_in_pkg::IDX_STATUS, 1 << (usb_in_pkg::FLAG_SETUP + n));
            chk("sys masked", 0, irq_sys);
            wr(usb_in_pkg::IDX_ENABLE, usb_in_pkg::ENABLE_MASK);
            @(posedge clk);
            chk("sys irq", 1, irq_sys);
            wr(usb_in_pkg::IDX_CLEAR, 1 << (usb_in_pkg::FLAG_SETUP + n));
            @(posedge clk);
            chk("sys irq clr", 0, irq_sys);
        end
        wrap_up();
    end
endmodule
